// File: pkg/smsp_defines.vh
// Register map, field positions and reset values of the serial port
`ifndef SMSP_DEFINES_VH
`define SMSP_DEFINES_VH

// Register byte offsets (one word each)
`define SMSP_OFF_CTRL1   8'h00
`define SMSP_OFF_CTRL2   8'h04
`define SMSP_OFF_BAUD    8'h08
`define SMSP_OFF_STATUS  8'h0C
`define SMSP_OFF_DATA    8'h10

// Control 1 field positions
`define SMSP_C1_ENABLE   6
`define SMSP_C1_MASTER   4
`define SMSP_C1_CLOCK_POLARITY     3
`define SMSP_C1_CLOCK_PHASE     2
`define SMSP_C1_SELECT_OUTPUT_ENABLE     1
`define SMSP_C1_LSBF     0

// Control 2 field positions and writable bits
`define SMSP_C2_MFE      4
`define SMSP_C2_BIDIR_OUTPUT_ENABLE  3
`define SMSP_C2_SWS      0
`define SMSP_C2_MASK     8'h19

// Baud register fields and writable bits
`define SMSP_BAUD_PRE_HI 6
`define SMSP_BAUD_PRE_LO 4
`define SMSP_BAUD_RATE_HI 2
`define SMSP_BAUD_RATE_LO 0
`define SMSP_BAUD_MASK   8'h77

// Status field positions
`define SMSP_ST_RXFULL   7
`define SMSP_ST_TXEMPTY  5
`define SMSP_ST_FAULT    4

// Reset values
`define SMSP_RST_CTRL1   8'h04
`define SMSP_RST_CTRL2   8'h00
`define SMSP_RST_BAUD    8'h00
`define SMSP_RST_SYNC    4'h8

// Last edge index of an eight-bit transfer
`define SMSP_LAST_EDGE   4'hF

`endif

// File: src/smsp_port.v
// Full-duplex serial port, master or slave, with AHB-Lite registers
// Function
// RULE1: Master bit rate max bus/2, slave bus/4
// RULE2: Only master starts; both shifters exchange contents
// RULE3: Master drives shift clock; slave takes it
// RULE4: Slave shifts only while select held low
// RULE5: Data write fills transmit buffer, loaded at start
// RULE6: Completed byte copied to receive buffer
// RULE7: Master: clock out, data out MOSI, in MISO
// RULE8: Slave: clock in, data out MISO, in MOSI
// RULE9: Prescaler divides bus clock by 1 to 8
// RULE10: Rate field divides further by 2 to 256
// RULE11: Disabled unit releases all four pins
// RULE12: Single-wire master uses MOSI, releases MISO
// RULE13: Single-wire slave uses MISO, releases MOSI
// RULE14: Bidir output enable sets data pin direction
// RULE15: Slave select pin is always select input
// RULE16: Master without fault detect releases select pin
// RULE17: Fault detect: fault input or automatic select output
// RULE18: Every stop mode disables the unit
// RULE19: Deep stop powers down, returns in reset state
// RULE20: Light stop freezes registers; reset exit resets
// RULE21: Interrupt exit from light stop resumes state
// RULE22: Five eight-bit software registers
// RULE23: Disable aborts, clears buffers, flags to idle
// RULE24: Clock polarity selects idle low or high
// RULE25: Clock phase places first edge mid or start
// RULE26: Shift direction selects MSB or LSB first
`timescale 1ns/10ps
`include "smsp_defines.vh"

module smsp_port (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Low-power state from the system controller
  input  wire        stopLight,
  input  wire        stopDeep,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // Shift clock pin
  input  wire        sckIn,
  output wire        sckOut,
  output wire        sckOe_n,
  // Master out, slave in pin
  input  wire        mosiIn,
  output wire        mosiOut,
  output wire        mosiOe_n,
  // Master in, slave out pin
  input  wire        misoIn,
  output wire        misoOut,
  output wire        misoOe_n,
  // Select pin
  input  wire        ssIn,
  output wire        ssOut,
  output wire        select_output_enable_n
);

  // Pin synchronisers: bit 0 clock, 1 mosi, 2 miso, 3 select
  wire [3:0] pinRaw = {ssIn, misoIn, mosiIn, sckIn};
  reg  [3:0] syncA_reg;          // First stage, read only by second
  reg  [3:0] syncB_reg;          // Second stage, safe to use
  reg        sckDly_reg;         // Previous synced clock for edges

  localparam [3:0] syncRst = `SMSP_RST_SYNC; // Idle levels, select high

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gSync
      // Two flops per pin before any logic looks at it
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          syncA_reg[gi] <= syncRst[gi];
          syncB_reg[gi] <= syncRst[gi];
        end else begin
          syncA_reg[gi] <= pinRaw[gi];
          syncB_reg[gi] <= syncA_reg[gi];
        end
      end
    end
  endgenerate

  // Software registers
  reg  [7:0]  ctrl1_reg;         // Enable, mode, clock format
  reg  [7:0]  ctrl2_reg;         // Fault detect, bidir controls
  reg  [7:0]  baud_reg;          // Prescale and rate selects
  reg  [7:0]  txBuf_reg;         // Transmit buffer
  reg  [7:0]  rxBuf_reg;         // Receive buffer
  reg         txEmpty_reg;       // Transmit buffer empty flag
  reg         rxFull_reg;        // Receive buffer full flag
  reg         modeFault_reg;     // Mode fault flag

  // Shift engine state
  reg         busy_reg;          // Transfer in progress
  reg  [3:0]  edgeCnt_reg;       // Clock edge index 0..15
  reg  [10:0] halfCnt_reg;       // Bus cycles in the half bit
  reg         sckLevel_reg;      // Master clock before polarity
  reg  [7:0]  shift_reg;         // The one shift register
  reg         inBit_reg;         // Sampled bit awaiting shift
  reg         tailPend_reg;      // Exchange shift owed after last edge

  // Bus state
  reg         wrPend_reg;        // Write data phase pending
  reg  [7:0]  wrAddr_reg;        // Address of that write
  reg  [7:0]  rdData_reg;        // Read data for the data phase

  // Control fields
  wire unitEnable   = ctrl1_reg[`SMSP_C1_ENABLE];
  wire masterSelect = ctrl1_reg[`SMSP_C1_MASTER];
  wire clockPol     = ctrl1_reg[`SMSP_C1_CLOCK_POLARITY];
  wire clockPhase   = ctrl1_reg[`SMSP_C1_CLOCK_PHASE];
  wire selOutEnable = ctrl1_reg[`SMSP_C1_SELECT_OUTPUT_ENABLE];
  wire lsbFirst     = ctrl1_reg[`SMSP_C1_LSBF];
  wire faultDetEn   = ctrl2_reg[`SMSP_C2_MFE];
  wire bidirOutEn   = ctrl2_reg[`SMSP_C2_BIDIR_OUTPUT_ENABLE];
  wire singleWire   = ctrl2_reg[`SMSP_C2_SWS];
  wire [2:0] prescaleSel =
    baud_reg[`SMSP_BAUD_PRE_HI:`SMSP_BAUD_PRE_LO];
  wire [2:0] rateSel = baud_reg[`SMSP_BAUD_RATE_HI:`SMSP_BAUD_RATE_LO];

  // Any stop mode takes the port off the pins
  wire active = unitEnable & ~stopLight & ~stopDeep;          // RULE18
  wire isMaster = active & masterSelect;
  wire isSlave  = active & ~masterSelect;

  // Half bit = (prescale+1) << rate, so the full bit is
  // (prescale+1) * 2^(rate+1) bus clocks, never under two
  wire [3:0]  preDiv    = {1'b0, prescaleSel} + 4'h1;          // RULE9
  wire [10:0] halfSpan  = {7'h00, preDiv} << rateSel;          // RULE10
  wire [10:0] halfLimit = halfSpan - 11'h001;                  // RULE1

  // Synced pin levels
  wire sckSync  = syncB_reg[0];
  wire mosiSync = syncB_reg[1];
  wire misoSync = syncB_reg[2];
  wire ssSync   = syncB_reg[3];

  // Slave is addressed only while select is low
  wire slaveSel = isSlave & ~ssSync;                           // RULE4 RULE15

  // Fault input: master, fault detect on, select output off
  wire faultIn = isMaster & faultDetEn & ~selOutEnable & ~ssSync; // RULE17

  // Serial data input routing per mode
  wire dataIn = masterSelect ? (singleWire ? mosiSync : misoSync) // RULE7
                             : (singleWire ? misoSync : mosiSync); // RULE8

  // Edge events: own divider as master, pin edges as slave
  wire mTick = busy_reg & isMaster & (halfCnt_reg == halfLimit);
  wire sEdge = busy_reg & slaveSel & (sckSync != sckDly_reg);  // RULE3
  wire shEvt = mTick | sEdge;

  // Sample on even edges for phase 0, odd edges for phase 1
  wire sampleEdge = clockPhase ? edgeCnt_reg[0] : ~edgeCnt_reg[0]; // RULE25
  wire lastEdge   = (edgeCnt_reg == `SMSP_LAST_EDGE);
  wire lastBit    = clockPhase ? dataIn : inBit_reg;

  // Bit leaving the shifter
  wire outBit = lsbFirst ? shift_reg[0] : shift_reg[7];        // RULE26

  // A data write landing in the cycle of a load refills the buffer
  wire txWrite = wrPend_reg & unitEnable & (wrAddr_reg == `SMSP_OFF_DATA);

  // Shift one bit in at the side opposite the leaving bit
  function [7:0] shiftIn;
    input [7:0] cur;
    input       lsbf;
    input       b;
    begin
      shiftIn = lsbf ? {b, cur[7:1]} : {cur[6:0], b};          // RULE26
    end
  endfunction

  // AHB address phase acceptance
  wire addrPhase = hsel & htrans[1] & hready;
  wire [7:0] addrLo = haddr[7:0];

  // Read mux for the address being taken
  reg [7:0] rdMux;
  always @* begin
    case (addrLo)
      `SMSP_OFF_CTRL1:  rdMux = ctrl1_reg;
      `SMSP_OFF_CTRL2:  rdMux = ctrl2_reg;
      `SMSP_OFF_BAUD:   rdMux = baud_reg;
      `SMSP_OFF_STATUS: rdMux = {rxFull_reg, 1'b0, txEmpty_reg,
                                 modeFault_reg, 4'h0};
      `SMSP_OFF_DATA:   rdMux = rxBuf_reg;                     // RULE6
      default:          rdMux = 8'h00;
    endcase
  end

  // Previous synced shift clock level, for slave edge detection
  always @(posedge clk_sys) begin
    if (!rst_n || stopDeep) begin                              // RULE19
      sckDly_reg <= 1'b0;
    end else if (!stopLight) begin                             // RULE20
      sckDly_reg <= sckSync;
    end
  end

  // Registers, flags and the shift engine
  always @(posedge clk_sys) begin
    if (!rst_n || stopDeep) begin                              // RULE19 RULE20
      ctrl1_reg     <= `SMSP_RST_CTRL1;
      ctrl2_reg     <= `SMSP_RST_CTRL2;
      baud_reg      <= `SMSP_RST_BAUD;
      txBuf_reg     <= 8'h00;
      rxBuf_reg     <= 8'h00;
      txEmpty_reg   <= 1'b1;
      rxFull_reg    <= 1'b0;
      modeFault_reg <= 1'b0;
      busy_reg      <= 1'b0;
      edgeCnt_reg   <= 4'h0;
      halfCnt_reg   <= 11'h000;
      sckLevel_reg  <= 1'b0;
      shift_reg     <= 8'h00;
      inBit_reg     <= 1'b0;
      tailPend_reg  <= 1'b0;
      wrPend_reg    <= 1'b0;
      wrAddr_reg    <= 8'h00;
      rdData_reg    <= 8'h00;
    end else if (stopLight) begin
      // Clocks halted: everything but a pending write holds, later resumes as is
      wrPend_reg <= 1'b0;                                      // RULE21
    end else begin
      // Address phase: capture write, prepare read data
      wrPend_reg <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_reg <= addrLo;
      end
      if (addrPhase && !hwrite) begin
        rdData_reg <= rdMux;
        // Reading data empties the receive buffer
        if (addrLo == `SMSP_OFF_DATA) begin
          rxFull_reg <= 1'b0;
        end
      end

      // Data phase of a write
      if (wrPend_reg) begin
        case (wrAddr_reg)
          `SMSP_OFF_CTRL1: begin
            ctrl1_reg     <= hwdata[7:0];
            modeFault_reg <= 1'b0;
          end
          `SMSP_OFF_CTRL2: ctrl2_reg <= hwdata[7:0] & `SMSP_C2_MASK;
          `SMSP_OFF_BAUD:  baud_reg  <= hwdata[7:0] & `SMSP_BAUD_MASK;
          `SMSP_OFF_DATA: begin
            if (unitEnable) begin
              txBuf_reg   <= hwdata[7:0];                      // RULE5
              txEmpty_reg <= 1'b0;
            end
          end
          default: ;
        endcase
      end

      if (!unitEnable) begin
        // Disabled: abort, clear buffers, flags to idle state
        busy_reg     <= 1'b0;                                  // RULE23
        edgeCnt_reg  <= 4'h0;
        halfCnt_reg  <= 11'h000;
        sckLevel_reg <= 1'b0;
        txBuf_reg    <= 8'h00;
        rxBuf_reg    <= 8'h00;
        txEmpty_reg  <= 1'b1;
        rxFull_reg   <= 1'b0;
        tailPend_reg <= 1'b0;
      end else if (faultIn) begin
        // Another master pulled select: drop to slave, abort
        modeFault_reg <= 1'b1;                                 // RULE17
        ctrl1_reg[`SMSP_C1_MASTER] <= 1'b0;
        busy_reg      <= 1'b0;
        sckLevel_reg  <= 1'b0;
        tailPend_reg  <= 1'b0;
      end else if (!busy_reg) begin
        edgeCnt_reg  <= 4'h0;
        halfCnt_reg  <= 11'h000;
        sckLevel_reg <= 1'b0;
        tailPend_reg <= 1'b0;
        // Owed exchange shift; a new load below overrides it
        if (tailPend_reg) begin
          shift_reg <= shiftIn(shift_reg, lsbFirst, inBit_reg);  // RULE2
        end
        if (isMaster && !txEmpty_reg) begin
          // Only the master starts, and only with data queued
          shift_reg   <= txBuf_reg;                            // RULE2 RULE5
          txEmpty_reg <= ~txWrite;
          busy_reg    <= 1'b1;
        end else if (slaveSel) begin
          // Slave arms on select; stale shifter if nothing queued
          if (!txEmpty_reg) begin
            shift_reg   <= txBuf_reg;                          // RULE5
            txEmpty_reg <= ~txWrite;
          end
          busy_reg <= 1'b1;
        end
      end else if (isSlave && !slaveSel) begin
        // Select released mid byte: partial byte is dropped
        busy_reg <= 1'b0;                                      // RULE4
      end else begin
        if (isMaster) begin
          halfCnt_reg <= mTick ? 11'h000 : halfCnt_reg + 11'h001;
        end
        if (shEvt) begin
          edgeCnt_reg <= edgeCnt_reg + 4'h1;
          if (isMaster) begin
            sckLevel_reg <= ~sckLevel_reg;                     // RULE3
          end
          if (lastEdge) begin
            // Byte complete: hand to receiver; the shifter moves a
            // cycle later so data hold past a last sampling edge
            rxBuf_reg    <= shiftIn(shift_reg, lsbFirst, lastBit); // RULE6
            inBit_reg    <= lastBit;
            tailPend_reg <= 1'b1;
            rxFull_reg   <= 1'b1;
            busy_reg     <= 1'b0;
          end else if (sampleEdge) begin
            inBit_reg <= dataIn;
          end else if (edgeCnt_reg != 4'h0) begin
            shift_reg <= shiftIn(shift_reg, lsbFirst, inBit_reg);
          end
        end
      end
    end
  end

  // Select pin role as master
  wire ssAutoOut = isMaster & faultDetEn & selOutEnable;       // RULE16 RULE17

  // Pin drivers; output enables are low while this port drives
  assign sckOut   = sckLevel_reg ^ clockPol;                   // RULE24
  assign sckOe_n  = ~isMaster;                                 // RULE7 RULE11
  assign mosiOut  = outBit;
  assign mosiOe_n = ~(isMaster & (~singleWire | bidirOutEn));  // RULE12 RULE14
  assign misoOut  = outBit;
  assign misoOe_n = ~(slaveSel & (~singleWire | bidirOutEn));  // RULE8 RULE13
  // Select stays low one cycle past a last edge that samples
  assign ssOut    = ~(busy_reg | (tailPend_reg & clockPhase));
  assign select_output_enable_n   = ~ssAutoOut;                                // RULE11

  // Bus answers: no wait states, always OKAY, byte in low lane
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h000000, rdData_reg};                 // RULE22

endmodule // smsp_port

// File: verification/smsp_checker.sv
// Port-level assertions for the serial port block
`timescale 1ns/10ps
module smsp_checker (
  // Clock, reset and stop state
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        stopLight,
  input wire logic        stopDeep,
  // Bus answer
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pin enables and select
  input wire logic        sckOe_n,
  input wire logic        mosiOe_n,
  input wire logic        misoOe_n,
  input wire logic        select_output_enable_n,
  input wire logic        ssOut,
  input wire logic        ssIn
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // All four pins handed back to the general port
  wire allOff = sckOe_n & mosiOe_n & misoOe_n & select_output_enable_n;

  bus_okay_a:
    assert property (hreadyout && !hresp)
    else $error("Bus answer not ready or not okay");
  read_width_a:
    assert property (hrdata[31:8] == 24'h0)
    else $error("Upper read data bits not zero");
  reset_pins_a:
    assert property (disable iff (1'b0) !rst_n |=> allOff)
    else $error("Pins driven after reset");
  deep_stop_a:
    assert property (stopDeep |=> allOff)
    else $error("Pins driven in deep stop");
  light_stop_a:
    assert property (stopLight |=> allOff)
    else $error("Pins driven in light stop");
  master_pins_a:
    assert property (!sckOe_n |-> misoOe_n)
    else $error("Master drives its data input pin");
  slave_pins_a:
    assert property (!misoOe_n |-> sckOe_n && select_output_enable_n)
    else $error("Slave drives clock or select pin");
  ss_master_a:
    assert property (!select_output_enable_n |-> !sckOe_n)
    else $error("Select output driven outside master mode");
  select_gate_a:
    assert property ($fell(misoOe_n) |-> !ssIn && !$past(ssIn))
    else $error("Slave output enabled without select");
endmodule // smsp_checker

bind smsp_port smsp_checker chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .stopLight(stopLight),
  .stopDeep(stopDeep), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sckOe_n(sckOe_n), .mosiOe_n(mosiOe_n),
  .misoOe_n(misoOe_n), .select_output_enable_n(select_output_enable_n), .ssOut(ssOut), .ssIn(ssIn));

// File: verification/smsp_slave_model.sv
// Behavioural external peripheral on the serial link
`timescale 1ns/10ps
module smsp_slave_model (
  // Link pins seen from the peripheral
  input  wire logic       sck,
  input  wire logic       selN,
  input  wire logic       mosi,
  output logic            miso,
  // Clock format and data
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic [7:0] txByte,
  output logic [7:0]      rxByte
);
  logic [7:0] tx; // Byte being shifted out
  int         n;  // Bits already presented
  // Sample edge rises and drive edge falls in every format
  wire s = sck ^ clock_polarity ^ clock_phase;

  initial begin
    miso = 1'b0;
    rxByte = 8'h00;
  end
  // Select starts a byte; phase 0 shows the first bit at once
  always @(negedge selN) begin
    tx = txByte;
    n = 0;
    if (!clock_phase) begin
      miso = tx[7];
      n = 1;
    end
  end
  // Next bit on each drive edge, MSB first
  always @(negedge s) if (!selN && n < 8) begin
    miso = tx[7 - n];
    n = n + 1;
  end
  // Capture on the sample edge
  always @(posedge s) if (!selN) rxByte = {rxByte[6:0], mosi};
  // Released line must not keep its last level
  always @(posedge selN) miso = ~miso;
endmodule // smsp_slave_model

// File: verification/smsp_port_tb.sv
// Self-checking bench for the serial port block
`timescale 1ns/10ps
`include "smsp_defines.vh"
module smsp_port_tb;
  // Driven inputs
  logic        clk_sys = 0, rst_n = 0, stopLight = 0, stopDeep = 0;
  logic        hsel = 0, hwrite = 0, tbSck = 0, tbMosi = 0, tbSs = 1;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  // Bench state
  logic        mCpol = 0, mCpha = 0, lsb, prevSck = 0;
  logic [7:0]  mTx = 0, q, hb, got;
  int          n_mismatch = 0, checks_done = 0, i, runLen = 0, lastRun;
  logic [7:0]  bTab [5] = '{8'h21, 8'h02, 8'h30, 8'h72, 8'h07};
  // Control 1, control 2, expected enables sck/ss/mosi/miso
  logic [19:0] pinTab [9] = '{20'h0000F, 20'h52005, 20'h50105,
    20'h52101, 20'h52017, 20'h52095, 20'h4000E, 20'h4009E, 20'h4001F};
  // Design outputs
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, sckOut, sckOe_n, mosiOut, mosiOe_n;
  wire         misoOut, misoOe_n, ssOut, select_output_enable_n, mMiso;
  wire  [7:0]  mRx;
  // Resolved pins; the peer is selected only by the automatic select
  wire sckW  = sckOe_n ? tbSck : sckOut;
  wire mosiW = mosiOe_n ? tbMosi : mosiOut;
  wire misoW = misoOe_n ? mMiso : misoOut;
  wire ssW   = select_output_enable_n ? tbSs : ssOut;
  wire mSel  = select_output_enable_n | ssOut;

  always #2 clk_sys = ~clk_sys;

  smsp_port uut (.clk_sys(clk_sys), .rst_n(rst_n), .stopLight(stopLight),
    .stopDeep(stopDeep), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sckIn(sckW),
    .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiIn(mosiW), .mosiOut(mosiOut),
    .mosiOe_n(mosiOe_n), .misoIn(misoW), .misoOut(misoOut),
    .misoOe_n(misoOe_n), .ssIn(ssW), .ssOut(ssOut), .select_output_enable_n(select_output_enable_n));
  smsp_slave_model peer (.sck(sckW), .selN(mSel), .mosi(mosiW),
    .miso(mMiso), .clock_polarity(mCpol), .clock_phase(mCpha), .txByte(mTx), .rxByte(mRx));

  // Length of the last steady shift clock level, in bus cycles
  always @(posedge clk_sys) begin
    prevSck <= sckW;
    if (sckW !== prevSck) begin
      lastRun <= runLen;
      runLen <= 1;
    end else runLen <= runLen + 1;
  end

  // One single word transfer; read data lands in q
  task ahb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, 24'h0, d};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask
  task chk(input logic [7:0] e);
    checks_done++;
    if (q !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, q, e);
    end
  endtask
  task rdChk(input logic [7:0] a, input logic [7:0] e);
    ahb(a, 1'b0, 8'h00);
    chk(e);
  endtask
  // Poll until a received byte is waiting
  task waitRx;
    do ahb(`SMSP_OFF_STATUS, 1'b0, 8'h00); while (q[7] !== 1'b1);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++)
      rev[k] = v[7 - k];
  endfunction
  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, well beyond the longest byte
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1;
    // Reset values, writable masks, unmapped offset
    rdChk(`SMSP_OFF_CTRL1, `SMSP_RST_CTRL1);
    rdChk(`SMSP_OFF_STATUS, 8'h20);
    ahb(`SMSP_OFF_CTRL2, 1'b1, 8'hFF);
    rdChk(`SMSP_OFF_CTRL2, `SMSP_C2_MASK);
    ahb(`SMSP_OFF_BAUD, 1'b1, 8'hFF);
    rdChk(`SMSP_OFF_BAUD, `SMSP_BAUD_MASK);
    rdChk(8'h14, 8'h00);
    // A data write while off must not start anything
    ahb(`SMSP_OFF_DATA, 1'b1, 8'hA5);
    rdChk(`SMSP_OFF_STATUS, 8'h20);
    // Pin routing in every mode; select high only for master rows
    for (i = 0; i < 9; i++) begin
      tbSs <= pinTab[i][16];
      ahb(`SMSP_OFF_CTRL2, 1'b1, pinTab[i][11:4]);
      ahb(`SMSP_OFF_CTRL1, 1'b1, pinTab[i][19:12]);
      repeat (4) @(posedge clk_sys);
      q = {4'h0, sckOe_n, select_output_enable_n, mosiOe_n, misoOe_n};
      chk({4'h0, pinTab[i][3:0]});
    end
    // Select pulled low under fault detect drops master mode
    tbSs <= 0;
    ahb(`SMSP_OFF_CTRL2, 1'b1, 8'h10);
    ahb(`SMSP_OFF_CTRL1, 1'b1, 8'h50);
    repeat (6) @(posedge clk_sys);
    rdChk(`SMSP_OFF_STATUS, 8'h30);
    rdChk(`SMSP_OFF_CTRL1, 8'h40);
    // Master bytes in all clock formats, then LSB first
    tbSs <= 1;
    for (i = 0; i < 5; i++) begin
      {mCpol, mCpha} = i[1:0];
      lsb = (i == 4);
      mTx = 8'h96 ^ {5'h0, i[2:0]};
      hb = ({5'h0, bTab[i][6:4]} + 8'h01) << bTab[i][2:0];
      ahb(`SMSP_OFF_BAUD, 1'b1, bTab[i]);
      ahb(`SMSP_OFF_CTRL1, 1'b1, {4'h5, i[1:0], 1'b1, lsb});
      ahb(`SMSP_OFF_DATA, 1'b1, ~mTx);
      waitRx;
      rdChk(`SMSP_OFF_DATA, lsb ? rev(mTx) : mTx);
      q = mRx;
      chk(lsb ? rev(~mTx) : ~mTx);
      q = lastRun[7:0];
      chk(hb);
      q = {7'h0, sckOut};
      chk({7'h0, i[1]});
    end
    // Disable in mid-byte aborts and clears
    ahb(`SMSP_OFF_DATA, 1'b1, 8'h3C);
    repeat (100) @(posedge clk_sys);
    ahb(`SMSP_OFF_CTRL1, 1'b1, 8'h00);
    rdChk(`SMSP_OFF_STATUS, 8'h20);
    rdChk(`SMSP_OFF_DATA, 8'h00);
    // Slave byte clocked by the bench, format 0
    ahb(`SMSP_OFF_CTRL1, 1'b1, 8'h40);
    ahb(`SMSP_OFF_DATA, 1'b1, 8'hC6);
    tbSs <= 0;
    repeat (8) @(posedge clk_sys);
    for (i = 7; i >= 0; i--) begin
      tbMosi <= i[0] ^ i[2];
      repeat (4) @(posedge clk_sys);
      got[i] = misoW;
      tbSck <= 1;
      repeat (8) @(posedge clk_sys);
      tbSck <= 0;
      repeat (4) @(posedge clk_sys);
    end
    tbSs <= 1;
    waitRx;
    rdChk(`SMSP_OFF_DATA, 8'h5A);
    q = got;
    chk(8'hC6);
    // Light stop freezes, deep stop resets
    ahb(`SMSP_OFF_CTRL2, 1'b1, 8'h08);
    stopLight <= 1;
    ahb(`SMSP_OFF_CTRL2, 1'b1, 8'h10);
    // Read data register is frozen too: still the last byte read
    rdChk(`SMSP_OFF_CTRL2, 8'h5A);
    stopLight <= 0;
    rdChk(`SMSP_OFF_CTRL2, 8'h08);
    stopDeep <= 1;
    repeat (3) @(posedge clk_sys);
    stopDeep <= 0;
    rdChk(`SMSP_OFF_CTRL1, `SMSP_RST_CTRL1);
    rdChk(`SMSP_OFF_CTRL2, `SMSP_RST_CTRL2);
    test_done;
  end
endmodule // smsp_port_tb
